// [sweep_pkg.sv]
// Purpose: shared constants and types of the repeating sweep sequencer
// Assumes: 32-bit AXI4-Lite register bus, 100 MHz aclk
// Notes:   offsets are byte addresses of aligned words
package sweep_pkg;

   // ----------------------------------------------------------------
   // bus and register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam int          RES_W           = 10;
   localparam int          N_INPUTS        = 8;
   localparam logic [7:0]  OFS_CTRL_FIRST  = 8'h00;
   localparam logic [7:0]  OFS_CTRL_SECOND = 8'h04;
   localparam logic [7:0]  OFS_CTRL_THIRD  = 8'h08;
   localparam logic [7:0]  OFS_STATUS      = 8'h0c;
   localparam logic [7:0]  OFS_RES_BASE    = 8'h20;
   localparam logic [7:0]  OFS_RES_LAST    = 8'h3c;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int          TSS_BIT         = 0;
   localparam int          RUN_BIT         = 1;
   localparam int          SEL_LSB         = 0;
   localparam int          MODE_BIT        = 2;
   localparam int          GROUP_LSB       = 0;
   localparam int          ST_LSB          = 0;
   localparam int          CHAN_LSB        = 4;
   localparam int          PRIO_BIT        = 8;

   // ----------------------------------------------------------------
   // codes and reset values
   // ----------------------------------------------------------------
   localparam logic        MODE_SWEEP0     = 1'h0;
   localparam logic        MODE_SWEEP1     = 1'h1;
   localparam logic        TSS_SOFTWARE    = 1'h0;
   localparam logic [2:0]  CHAN_FIRST      = 3'h0;
   localparam logic [2:0]  CHAN_LAST       = 3'h7;
   localparam logic [2:0]  CHAN_STEP       = 3'h1;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_ARM  = 2'b01,
      ST_CONV = 2'b10
   } seq_state_t;

   // request to the analog multiplexer and converter core
   typedef struct packed
   {
      logic       start;
      logic [1:0] group;
      logic [2:0] chan;
   } conv_req_t;

   // answer of the converter core
   typedef struct packed
   {
      logic             done;
      logic [RES_W-1:0] data;
   } conv_rsp_t;

endpackage

// [fall_detect.sv]
// Purpose: registered falling edge detector for the trigger pin
// Assumes: pin is synchronous to aclk
// Notes:   pulse is one cycle, one cycle after the edge
`timescale 1ns/1ns
module fall_detect
   import sweep_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic pin,
   output logic      fall
);

   typedef struct packed
   {
      logic prev;
      logic fall;
   } fall_state_t;

   fall_state_t q;
   fall_state_t d;

   // ----------------------------------------------------------------
   // edge logic
   // ----------------------------------------------------------------
   always_comb
   begin
      d      = q;
      d.prev = pin;
      d.fall = q.prev && !pin;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q <= '{prev: 1'b0, fall: 1'b0};
      end
      else
      begin
         q <= d;
      end
   end

   assign fall = q.fall;

endmodule

// [sweep_sequencer.sv]
// Purpose: repeating sweep sequencer with AXI4-Lite registers
// Assumes: converter core answers each start with one done pulse
// Notes:   no interrupt output; results kept per input
// Operation
// - mode zero converts selected inputs in turn, wrapping to first, endlessly
// - sweep_select and input_group_select together pick the swept inputs
// - trigger select 0: writing run 1 starts converting at once
// - trigger select 1: conversion starts on the next trigger pin fall
// - converting continues until software writes run 0
// - no completion interrupt request in either repeating mode
// - mode zero sweeps inputs 0 up to 1, 3, 5 or 7
// - each result lands in that input's own result register
// - mode one priority set is input 0 up to 0, 1, 2 or 3
// - mode one converts the priority set between each other input
// - mode one visits one other group input each cycle, in turn, repeating
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module sweep_sequencer
   import sweep_pkg::*;
(
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [DATA_W-1:0]      rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              external_trigger_pin,
   output conv_req_t              conv_req,
   input  wire conv_rsp_t         conv_rsp
);

   typedef struct packed
   {
      seq_state_t                  st;
      logic [2:0]                  chan;
      logic [2:0]                  np;
      logic                        in_prio;
      logic                        tss;
      logic                        run;
      logic                        mode;
      logic [1:0]                  sweep_sel;
      logic [1:0]                  group;
      logic [N_INPUTS-1:0][RES_W-1:0] res;
      conv_req_t                   req;
      logic                        aw_have;
      logic [ADDR_W-1:0]           aw_addr;
      logic                        w_have;
      logic [DATA_W-1:0]           w_data;
      logic                        w_lane0;
      logic                        awready;
      logic                        wready;
      logic                        bvalid;
      logic [1:0]                  bresp;
      logic                        arready;
      logic                        rvalid;
      logic [1:0]                  rresp;
      logic [DATA_W-1:0]           rdata;
   } top_state_t;

   top_state_t q;
   top_state_t d;
   logic       trig_fall;
   logic [2:0] last0;
   logic [2:0] plast;
   logic       run_set;
   logic       run_clr;

   // ----------------------------------------------------------------
   // trigger edge
   // ----------------------------------------------------------------
   fall_detect u_trig
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin     (external_trigger_pin),
      .fall    (trig_fall)
   );

   // sweep ends from sweep_select
   assign last0 = {q.sweep_sel, 1'b1};
   assign plast = {1'b0, q.sweep_sel};

   // ----------------------------------------------------------------
   // register read
   // ----------------------------------------------------------------
   function automatic logic [33:0] read_reg(input logic [ADDR_W-1:0] a,
                                            input top_state_t s);
      logic [DATA_W-1:0] v;
      logic [1:0]        r;
      v = '0;
      r = RESP_OKAY;
      if (a == OFS_CTRL_FIRST)
      begin
         v[TSS_BIT] = s.tss;
         v[RUN_BIT] = s.run;
      end
      else if (a == OFS_CTRL_SECOND)
      begin
         v[SEL_LSB +: 2] = s.sweep_sel;
         v[MODE_BIT]     = s.mode;
      end
      else if (a == OFS_CTRL_THIRD)
      begin
         v[GROUP_LSB +: 2] = s.group;
      end
      else if (a == OFS_STATUS)
      begin
         v[ST_LSB +: 2]   = s.st;
         v[CHAN_LSB +: 3] = s.chan;
         v[PRIO_BIT]      = s.in_prio;
      end
      else if (a >= OFS_RES_BASE && a <= OFS_RES_LAST && a[1:0] == 2'h0)
      begin
         v[RES_W-1:0] = s.res[a[4:2]];
      end
      else
      begin
         r = RESP_SLVERR;
      end
      return {r, v};
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      d           = q;
      d.req.start = 1'b0;
      run_set     = 1'b0;
      run_clr     = 1'b0;

      // trigger wait
      if (q.st == ST_ARM && trig_fall)
      begin
         d.st        = ST_CONV;
         d.req.start = 1'b1;
      end

      // conversion done: store and step
      if (q.st == ST_CONV && conv_rsp.done)
      begin
         d.res[q.chan] = conv_rsp.data;
         d.req.start   = 1'b1;
         if (q.mode == MODE_SWEEP0)
         begin
            d.chan = (q.chan >= last0) ? CHAN_FIRST
                                       : q.chan + CHAN_STEP;
         end
         else if (q.in_prio)
         begin
            if (q.chan >= plast)
            begin
               d.in_prio = 1'b0;
               d.chan    = q.np;
            end
            else
            begin
               d.chan = q.chan + CHAN_STEP;
            end
         end
         else
         begin
            d.in_prio = 1'b1;
            d.chan    = CHAN_FIRST;
            d.np = (q.np == CHAN_LAST) ? plast + CHAN_STEP
                                       : q.np + CHAN_STEP;
         end
      end

      // write channels
      if (awvalid && q.awready)
      begin
         d.aw_have = 1'b1;
         d.aw_addr = awaddr;
      end
      if (wvalid && q.wready)
      begin
         d.w_have  = 1'b1;
         d.w_data  = wdata;
         d.w_lane0 = wstrb[0];
      end
      if (q.bvalid && bready)
      begin
         d.bvalid = 1'b0;
      end
      if (q.aw_have && q.w_have && !q.bvalid)
      begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = RESP_OKAY;
         if (q.aw_addr == OFS_CTRL_FIRST)
         begin
            if (q.w_lane0)
            begin
               d.tss   = q.w_data[TSS_BIT];
               d.run   = q.w_data[RUN_BIT];
               run_set = q.w_data[RUN_BIT] && !q.run;
               run_clr = !q.w_data[RUN_BIT];
            end
         end
         else if (q.aw_addr == OFS_CTRL_SECOND)
         begin
            if (q.w_lane0)
            begin
               d.sweep_sel = q.w_data[SEL_LSB +: 2];
               d.mode      = q.w_data[MODE_BIT];
            end
         end
         else if (q.aw_addr == OFS_CTRL_THIRD)
         begin
            if (q.w_lane0)
            begin
               d.group = q.w_data[GROUP_LSB +: 2];
            end
         end
         else if (q.aw_addr == OFS_STATUS || (q.aw_addr >= OFS_RES_BASE
                  && q.aw_addr <= OFS_RES_LAST && q.aw_addr[1:0] == 2'h0))
         begin
            d.bresp = RESP_OKAY;
         end
         else
         begin
            d.bresp = RESP_SLVERR;
         end
      end

      // start and stop from the run bit
      if (run_set)
      begin
         d.chan    = CHAN_FIRST;
         d.in_prio = 1'b1;
         d.np      = plast + CHAN_STEP;
         if (d.tss == TSS_SOFTWARE)
         begin
            d.st        = ST_CONV;
            d.req.start = 1'b1;
         end
         else
         begin
            d.st        = ST_ARM;
            d.req.start = 1'b0;
         end
      end
      else if (run_clr)
      begin
         d.st        = ST_IDLE;
         d.req.start = 1'b0;
      end

      d.req.chan = d.chan;
      d.req.group = q.group;
      d.awready  = !d.aw_have && !d.bvalid;
      d.wready   = !d.w_have && !d.bvalid;

      // read channels
      if (q.rvalid && rready)
      begin
         d.rvalid  = 1'b0;
         d.arready = 1'b1;
      end
      if (arvalid && q.arready)
      begin
         d.arready            = 1'b0;
         d.rvalid             = 1'b1;
         {d.rresp, d.rdata}   = read_reg(araddr, q);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         q         <= '0;
         q.st      <= ST_IDLE;
         q.awready <= 1'b1;
         q.wready  <= 1'b1;
         q.arready <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   assign awready  = q.awready;
   assign wready   = q.wready;
   assign bvalid   = q.bvalid;
   assign bresp    = q.bresp;
   assign arready  = q.arready;
   assign rvalid   = q.rvalid;
   assign rresp    = q.rresp;
   assign rdata    = q.rdata;
   assign conv_req = q.req;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sw_start_a: assert property
      (run_set && d.tss == TSS_SOFTWARE |=> conv_req.start
       && q.st == ST_CONV && conv_req.chan == CHAN_FIRST)
      else $error("software start did not convert at once");
   hw_wait_a: assert property
      (q.st == ST_ARM && !trig_fall && !run_set |=> !conv_req.start)
      else $error("converted before trigger fall");
   hw_start_a: assert property
      (q.st == ST_ARM && trig_fall && !run_clr |=> conv_req.start)
      else $error("trigger fall did not start conversion");
   stop_run_a: assert property
      (run_clr |=> q.st == ST_IDLE && !conv_req.start ##1 !conv_req.start)
      else $error("run cleared but sequencer kept going");
   no_self_stop_a: assert property
      (q.st == ST_CONV && !run_clr |=> q.st == ST_CONV)
      else $error("sweep stopped by itself");
   wrap_zero_a: assert property
      (q.st == ST_CONV && conv_rsp.done && q.mode == MODE_SWEEP0
       && q.chan == last0 && !run_set && !run_clr
       |=> conv_req.start && conv_req.chan == CHAN_FIRST)
      else $error("mode zero did not wrap to first input");
   range_zero_a: assert property
      (conv_req.start && q.mode == MODE_SWEEP0
       && $stable(q.sweep_sel) |-> conv_req.chan <= last0)
      else $error("mode zero input beyond selected range");
   result_a: assert property
      (q.st == ST_CONV && conv_rsp.done
       |=> q.res[$past(q.chan)] == $past(conv_rsp.data))
      else $error("result not stored for its input");
   group_a: assert property
      (conv_req.start |-> conv_req.group == $past(q.group))
      else $error("conversion in wrong group");
   prio_return_a: assert property
      (q.st == ST_CONV && conv_rsp.done && q.mode == MODE_SWEEP1
       && !q.in_prio && !run_set && !run_clr
       |=> conv_req.chan == CHAN_FIRST && q.in_prio)
      else $error("priority set not revisited");
   other_range_a: assert property
      (conv_req.start && q.mode == MODE_SWEEP1 && !q.in_prio
       && $stable(q.sweep_sel) |-> conv_req.chan > plast)
      else $error("other input inside priority set");
   sweep_wrap_c: cover property
      (q.st == ST_CONV && conv_rsp.done && q.chan == last0
       && q.mode == MODE_SWEEP0);
   hw_start_c: cover property (q.st == ST_ARM && trig_fall);
   mode1_wrap_c: cover property
      (q.mode == MODE_SWEEP1 && conv_req.start && conv_req.chan == CHAN_LAST);
   stop_c: cover property (q.st == ST_CONV && run_clr);

endmodule

// [conv_core_model.sv]
// Purpose: behavioural converter core beside the sweep sequencer
// Assumes: one start at a time, answered after lat cycles (lat >= 1)
// Notes:   result is tag, group and input, so each result can be traced
`timescale 1ns/1ns
module conv_core_model
   import sweep_pkg::*;
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire conv_req_t  conv_req,
   input  wire logic [3:0] lat,
   input  wire logic [4:0] tag,
   output conv_rsp_t       conv_rsp
);
   logic             busy_q;
   logic [3:0]       cnt_q;
   logic [RES_W-1:0] pend_q;

   // ----------------------------------------------------------------
   // conversion timing and result
   // ----------------------------------------------------------------
   always @(posedge aclk)
      if (!aresetn)
      begin
         busy_q   <= 1'b0;
         cnt_q    <= 4'h0;
         pend_q   <= 10'h000;
         conv_rsp <= 11'h000;
      end
      else
      begin
         conv_rsp.done <= 1'b0;
         conv_rsp.data <= ~conv_rsp.data;
         if (conv_req.start)
         begin
            busy_q <= 1'b1;
            cnt_q  <= lat;
            pend_q <= {tag, conv_req.group, conv_req.chan};
         end
         else if (busy_q && cnt_q <= 4'h1)
         begin
            busy_q        <= 1'b0;
            conv_rsp.done <= 1'b1;
            conv_rsp.data <= pend_q;
         end
         else if (busy_q)
            cnt_q <= cnt_q - 4'h1;
      end
endmodule

// [adc_repeat_sweep_sequencer_tb_top.sv]
// Purpose: self-checking bench of the repeating sweep sequencer
// Assumes: converter core model on the far side
// Notes:   rows cover both modes, every sweep_select, three groups
`timescale 1ns/1ns
module adc_repeat_sweep_sequencer_tb_top
   import sweep_pkg::*;
;
   typedef struct packed
   {
      logic       mode;
      logic [1:0] sel;
      logic [1:0] grp;
      logic [3:0] lat;
   } row_t;

   localparam row_t ROWS [8] = '{
      '{1'h0, 2'h0, 2'h0, 4'h1}, '{1'h0, 2'h1, 2'h1, 4'h5},
      '{1'h0, 2'h2, 2'h2, 4'h1}, '{1'h0, 2'h3, 2'h0, 4'h3},
      '{1'h1, 2'h0, 2'h1, 4'h1}, '{1'h1, 2'h1, 2'h2, 4'h4},
      '{1'h1, 2'h2, 2'h0, 4'h1}, '{1'h1, 2'h3, 2'h1, 4'h2}};
   localparam logic [7:0] RST_ADDR [5] = '{OFS_CTRL_FIRST,
      OFS_CTRL_SECOND, OFS_CTRL_THIRD, OFS_RES_BASE, OFS_RES_LAST};

   logic              aclk                 = 1'b0;
   logic              aresetn              = 1'b0;
   logic [ADDR_W-1:0] awaddr               = 8'h00;
   logic [ADDR_W-1:0] araddr               = 8'h00;
   logic [DATA_W-1:0] wdata                = 32'h0;
   logic [3:0]        wstrb                = 4'h0;
   logic              awvalid              = 1'b0;
   logic              wvalid               = 1'b0;
   logic              bready               = 1'b0;
   logic              arvalid              = 1'b0;
   logic              rready               = 1'b0;
   logic              external_trigger_pin = 1'b1;
   logic [3:0]        lat                  = 4'h1;
   logic [4:0]        tag                  = 5'h00;
   logic [1:0]        g_exp                = 2'h0;
   logic              awready;
   logic              wready;
   logic              bvalid;
   logic              arready;
   logic              rvalid;
   logic [1:0]        bresp;
   logic [1:0]        rresp;
   logic [DATA_W-1:0] rdata;
   conv_req_t         conv_req;
   conv_rsp_t         conv_rsp;
   logic [31:0]       e;
   logic [2:0]        q [$];
   int                failures             = 0;
   int                samples_checked      = 0;

   always #5 aclk = ~aclk;

   sweep_sequencer u_sweep_sequencer (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .external_trigger_pin(external_trigger_pin),
      .conv_req(conv_req), .conv_rsp(conv_rsp));

   conv_core_model u_conv_core_model (
      .aclk(aclk), .aresetn(aresetn), .conv_req(conv_req),
      .lat(lat), .tag(tag), .conv_rsp(conv_rsp));

   // ----------------------------------------------------------------
   // compare, bus and closing tasks
   // ----------------------------------------------------------------
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                            input string what);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
      end
   endtask

   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: response %h not %h", $time, got, exp);
      end
   endtask

   task automatic wr_chk(input logic [7:0] a, input logic [31:0] v,
                         input logic [1:0] er,
                         input logic [3:0] s = 4'hf);
      logic got;
      got = 1'b0;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= v;
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!got)
      begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            check_resp(bresp, er);
            bready <= 1'b0;
            got = 1'b1;
         end
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ev,
                         input logic [1:0] er,
                         input logic [31:0] m = 32'hffffffff);
      logic got;
      got = 1'b0;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!got)
      begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            check_val(rdata & m, ev, "read data");
            check_resp(rresp, er);
            rready <= 1'b0;
            got = 1'b1;
         end
      end
   endtask

   function automatic logic [2:0] exp_chan(input row_t w, input int k);
      int p;
      p = int'(w.sel) + 1;
      if (w.mode == MODE_SWEEP0)
         return 3'(k % (2 * p));
      if (k % (p + 1) < p)
         return 3'(k % (p + 1));
      return 3'((k / (p + 1)) % (8 - p) + p);
   endfunction

   task automatic end_of_test();
      if (failures == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // start monitor and watchdog
   // ----------------------------------------------------------------
   always @(posedge aclk)
      if (conv_req.start === 1'b1)
      begin
         q.push_back(conv_req.chan);
         check_val(32'(conv_req.group), 32'(g_exp), "group");
      end

   initial
   begin
      repeat (20000) @(posedge aclk);
      failures++;
      end_of_test();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (RST_ADDR[j])
         rd_chk(RST_ADDR[j], 32'h0, RESP_OKAY);
      rd_chk(8'h10, 32'h0, RESP_SLVERR);
      wr_chk(8'h10, 32'h2, RESP_SLVERR);
      rd_chk(OFS_CTRL_FIRST, 32'h0, RESP_OKAY);
      foreach (ROWS[i])
      begin
         g_exp <= ROWS[i].grp;
         lat   <= ROWS[i].lat;
         tag   <= 5'(i + 1);
         e = {29'h0, ROWS[i].mode, ROWS[i].sel};
         wr_chk(OFS_CTRL_SECOND, e, RESP_OKAY);
         rd_chk(OFS_CTRL_SECOND, e, RESP_OKAY);
         wr_chk(OFS_CTRL_THIRD, {30'h0, ROWS[i].grp}, RESP_OKAY);
         q.delete();
         wr_chk(OFS_CTRL_FIRST, 32'h2, RESP_OKAY);
         repeat (2) @(posedge aclk);
         check_val(32'(q.size() > 0), 32'h1, "soft start");
         while (q.size() < 24)
            @(posedge aclk);
         wr_chk(OFS_CTRL_FIRST, 32'h0, RESP_OKAY);
         for (int k = 0; k < 24; k++)
            check_val(32'(q[k]), 32'(exp_chan(ROWS[i], k)), "input");
         q.delete();
         repeat (10) @(posedge aclk);
         check_val(32'(q.size()), 32'h0, "stop");
         for (int c = 0; c < 2; c++)
         begin
            e = {22'h0, tag, ROWS[i].grp, 3'(c)};
            rd_chk(OFS_RES_BASE + 8'(4 * c), e, RESP_OKAY);
         end
      end
      wr_chk(OFS_CTRL_SECOND, 32'h0, RESP_OKAY);
      wr_chk(OFS_CTRL_THIRD, 32'h0, RESP_OKAY);
      g_exp <= 2'h0;
      external_trigger_pin <= 1'b0;
      repeat (3) @(posedge aclk);
      external_trigger_pin <= 1'b1;
      q.delete();
      wr_chk(OFS_CTRL_FIRST, 32'h3, RESP_OKAY);
      repeat (10) @(posedge aclk);
      check_val(32'(q.size()), 32'h0, "early start");
      rd_chk(OFS_STATUS, 32'h1, RESP_OKAY, 32'h3);
      external_trigger_pin <= 1'b0;
      repeat (6) @(posedge aclk);
      check_val(32'(q.size() > 0), 32'h1, "trigger start");
      wr_chk(OFS_CTRL_FIRST, 32'h0, RESP_OKAY);
      external_trigger_pin <= 1'b1;
      // byte lane 0 off: write answered but ignored
      wr_chk(OFS_CTRL_SECOND, 32'h7, RESP_OKAY, 4'he);
      rd_chk(OFS_CTRL_SECOND, 32'h0, RESP_OKAY);
      // reset in mid-run halts the sweep and clears every register
      wr_chk(OFS_CTRL_FIRST, 32'h2, RESP_OKAY);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      q.delete();
      repeat (10) @(posedge aclk);
      check_val(32'(q.size()), 32'h0, "reset stop");
      wr_chk(OFS_RES_BASE, 32'h3ff, RESP_OKAY);
      foreach (RST_ADDR[j])
         rd_chk(RST_ADDR[j], 32'h0, RESP_OKAY);
      end_of_test();
   end
endmodule
